/* File: plc_cfg_pkg.sv */
// constants for the power-line master configuration bank
//
// Contract
// - Bit 6 of the system power register enables low-power mode and resets to 1.
// - Bits 7:6 of the drive register pick the transmit sink current, reset code 1.
// - Bits 1:0 of the drive register pick the pulse voltage threshold, reset code 1.
// - Each channel has a 3-bit overcurrent code (ch2 bits 5:3, ch1 bits 2:0), reset 6.
// - Channel 2 runs only while bit 7 is 1 and channel 1 only while bit 6 is 1.
// - Writing 1 to a resume bit resumes that channel from idle; hardware clears it when done.
// - A failed ping is retried as many times as bits 3:1 say, reset 2.
// - The ping retry limit governs all commands except bulk data-out requests.
// - When all retries fail the converter output is switched off and the slave disconnected.
// - Bit 0 of the retry register selects dual (0) or single (1) slave mode, reset 0.
// - Pings are issued every period field times 4 ms, field reset 0x18.
// - In bulk mode data-out NACKs are counted and an error flagged once past the limit.
// - Data-out retries equal the limit; 0xff retries forever.
// - The bulk retry limit acts only while bulk transfer mode is in use.
package plc_cfg_pkg;
	localparam logic [7:0] ADDR_SYS_POWER = 8'h30;
	localparam logic [7:0] ADDR_DRIVE = 8'h31;
	localparam logic [7:0] ADDR_OVERCURRENT = 8'h32;
	localparam logic [7:0] ADDR_CHAN_RETRY = 8'h33;
	localparam logic [7:0] ADDR_PING_PERIOD = 8'h34;
	localparam logic [7:0] ADDR_BULK_RETRY = 8'h35;
	localparam int LOW_PWR_BIT = 6;
	localparam int SINK_LSB = 6;
	localparam int THR_LSB = 0;
	localparam int CH2_OC_LSB = 3;
	localparam int CH1_OC_LSB = 0;
	localparam int CH2_EN_BIT = 7;
	localparam int CH1_EN_BIT = 6;
	localparam int CH2_RES_BIT = 5;
	localparam int CH1_RES_BIT = 4;
	localparam int PING_RTY_LSB = 1;
	localparam int MONO_BIT = 0;
	localparam logic [7:0] SYS_POWER_MASK = 8'h40;
	localparam logic [7:0] DRIVE_MASK = 8'hc3;
	localparam logic [7:0] OVERCURRENT_MASK = 8'h3f;
	localparam logic RST_LOW_PWR = 1'h1;
	localparam logic [1:0] RST_SINK = 2'h1;
	localparam logic [1:0] RST_THR = 2'h1;
	localparam logic [2:0] RST_OC = 3'h6;
	localparam logic RST_CH_EN = 1'h1;
	localparam logic [2:0] RST_PING_RTY = 3'h2;
	localparam logic RST_MONO = 1'h0;
	localparam logic [7:0] RST_PING_PERIOD = 8'h18;
	localparam logic [7:0] RST_BULK_RETRY = 8'hff;
	localparam logic [7:0] BULK_UNLIMITED = 8'hff;
	localparam int CLK_HZ = 25000000;
	localparam int PING_LSB_MS = 4;
	localparam int PING_LSB_CYCLES = CLK_HZ / 1000 * PING_LSB_MS;
	localparam int PING_MIN_MS = 100;
endpackage

/* File: plc_retry_ctr.sv */
// retry counter for one class of link exchange
`timescale 1ns/1ns
module plc_retry_ctr #(
	parameter int W = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic active_in,
	input wire logic fail_in,
	input wire logic ok_in,
	input wire logic [W-1:0] limit_in,
	input wire logic unlimited_in,
	output logic exhausted_out
);
	logic [W:0] cnt_q;
	logic [W:0] cnt_d;
	logic [W:0] lim_ext;

	assign lim_ext = {1'b0, limit_in};
	always_comb begin
		cnt_d = cnt_q;
		// clear on success
		if (ok_in || !active_in) begin
			cnt_d = '0;
		end else if (fail_in && !exhausted_out) begin
			cnt_d = cnt_q + {{W{1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// fails beyond the limit exhaust it; a fail beside a success still sets
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			exhausted_out <= 1'b0;
		end else if (active_in && fail_in && !unlimited_in
			&& cnt_q >= lim_ext) begin
			exhausted_out <= 1'b1;
		end else if (ok_in || !active_in) begin
			exhausted_out <= 1'b0;
		end
	end
endmodule

/* File: plc_master_config_bank.sv */
// configuration register bank of the two-channel power-line master
`timescale 1ns/1ns
module plc_master_config_bank
	import plc_cfg_pkg::*;
#(
	parameter int PING_LSB_CYC = PING_LSB_CYCLES
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// register port
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// link events from the channel engines
	input wire logic [1:0] resume_done_in,
	input wire logic cmd_ok_in,
	input wire logic cmd_fail_in,
	input wire logic bulk_mode_in,
	input wire logic dout_ack_in,
	input wire logic dout_nack_in,
	// configuration to the analog and link logic
	output logic low_power_en_out,
	output logic [1:0] tx_sink_current_sel_out,
	output logic [1:0] pulse_threshold_sel_out,
	output logic [2:0] ch2_overcurrent_limit_out,
	output logic [2:0] ch1_overcurrent_limit_out,
	output logic ch2_enable_out,
	output logic ch1_enable_out,
	output logic ch2_resume_request_out,
	output logic ch1_resume_request_out,
	output logic mono_slave_out,
	output logic ping_tick_out,
	output logic converter_off_out,
	output logic disconnect_out,
	output logic data_error_out
);
	logic low_pwr_q;
	logic [1:0] sink_q;
	logic [1:0] thr_q;
	logic [2:0] ch2_oc_q;
	logic [2:0] ch1_oc_q;
	logic ch2_en_q;
	logic ch1_en_q;
	logic ch2_res_q;
	logic ch1_res_q;
	logic [2:0] ping_rty_q;
	logic mono_q;
	logic [7:0] ping_period_q;
	logic [7:0] bulk_limit_q;
	logic [7:0] rdata_d;
	logic [31:0] lsb_cnt_q;
	logic [7:0] period_cnt_q;
	logic ping_tick_q;
	logic cmd_exhausted;
	logic dout_exhausted;
	logic conv_off_q;
	logic data_err_q;
	logic wr_chan;

	assign wr_chan = reg_wr_in && reg_addr_in == ADDR_CHAN_RETRY;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			low_pwr_q <= RST_LOW_PWR;
		end else if (reg_wr_in && reg_addr_in == ADDR_SYS_POWER) begin
			low_pwr_q <= reg_wdata_in[LOW_PWR_BIT];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sink_q <= RST_SINK;
			thr_q <= RST_THR;
		end else if (reg_wr_in && reg_addr_in == ADDR_DRIVE) begin
			sink_q <= reg_wdata_in[SINK_LSB +: 2];
			thr_q <= reg_wdata_in[THR_LSB +: 2];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ch2_oc_q <= RST_OC;
			ch1_oc_q <= RST_OC;
		end else if (reg_wr_in && reg_addr_in == ADDR_OVERCURRENT) begin
			ch2_oc_q <= reg_wdata_in[CH2_OC_LSB +: 3];
			ch1_oc_q <= reg_wdata_in[CH1_OC_LSB +: 3];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ch2_en_q <= RST_CH_EN;
			ch1_en_q <= RST_CH_EN;
			ping_rty_q <= RST_PING_RTY;
			mono_q <= RST_MONO;
		end else if (wr_chan) begin
			ch2_en_q <= reg_wdata_in[CH2_EN_BIT];
			ch1_en_q <= reg_wdata_in[CH1_EN_BIT];
			ping_rty_q <= reg_wdata_in[PING_RTY_LSB +: 3];
			mono_q <= reg_wdata_in[MONO_BIT];
		end
	end

	// resume requests, a write of 1 beats completion
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ch2_res_q <= 1'b0;
			ch1_res_q <= 1'b0;
		end else begin
			if (wr_chan && reg_wdata_in[CH2_RES_BIT]) begin
				ch2_res_q <= 1'b1;
			end else if (resume_done_in[1]) begin
				ch2_res_q <= 1'b0;
			end
			if (wr_chan && reg_wdata_in[CH1_RES_BIT]) begin
				ch1_res_q <= 1'b1;
			end else if (resume_done_in[0]) begin
				ch1_res_q <= 1'b0;
			end
		end
	end

	// period and bulk limit, value held as written
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ping_period_q <= RST_PING_PERIOD;
			bulk_limit_q <= RST_BULK_RETRY;
		end else if (reg_wr_in) begin
			if (reg_addr_in == ADDR_PING_PERIOD) begin
				ping_period_q <= reg_wdata_in;
			end
			if (reg_addr_in == ADDR_BULK_RETRY) begin
				bulk_limit_q <= reg_wdata_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lsb_cnt_q <= '0;
			period_cnt_q <= '0;
			ping_tick_q <= 1'b0;
		end else begin
			ping_tick_q <= 1'b0;
			if (lsb_cnt_q >= 32'(PING_LSB_CYC - 1)) begin
				lsb_cnt_q <= '0;
				if (period_cnt_q + 8'h01 >= ping_period_q) begin
					period_cnt_q <= '0;
					// a period of zero stops the pings
					ping_tick_q <= ping_period_q != 8'h00;
				end else begin
					period_cnt_q <= period_cnt_q + 8'h01;
				end
			end else begin
				lsb_cnt_q <= lsb_cnt_q + 32'h1;
			end
		end
	end

	plc_retry_ctr #(
		.W(3)
	) cmd_retry (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.active_in(1'b1),
		.fail_in(cmd_fail_in),
		.ok_in(cmd_ok_in),
		.limit_in(ping_rty_q),
		.unlimited_in(1'b0),
		.exhausted_out(cmd_exhausted)
	);

	plc_retry_ctr #(
		.W(8)
	) dout_retry (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.active_in(bulk_mode_in),
		.fail_in(dout_nack_in),
		.ok_in(dout_ack_in),
		.limit_in(bulk_limit_q),
		.unlimited_in(bulk_limit_q == BULK_UNLIMITED),
		.exhausted_out(dout_exhausted)
	);

	// shut down after retries run out, sticky until reset
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			conv_off_q <= 1'b0;
		end else if (cmd_exhausted) begin
			conv_off_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			data_err_q <= 1'b0;
		end else begin
			data_err_q <= dout_exhausted;
		end
	end

	// read mux, reserved and unmapped bits read 0
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr_in)
			ADDR_SYS_POWER: begin
				rdata_d[LOW_PWR_BIT] = low_pwr_q;
			end
			ADDR_DRIVE: begin
				rdata_d[SINK_LSB +: 2] = sink_q;
				rdata_d[THR_LSB +: 2] = thr_q;
			end
			ADDR_OVERCURRENT: begin
				rdata_d[CH2_OC_LSB +: 3] = ch2_oc_q;
				rdata_d[CH1_OC_LSB +: 3] = ch1_oc_q;
			end
			ADDR_CHAN_RETRY: begin
				rdata_d[CH2_EN_BIT] = ch2_en_q;
				rdata_d[CH1_EN_BIT] = ch1_en_q;
				rdata_d[CH2_RES_BIT] = ch2_res_q;
				rdata_d[CH1_RES_BIT] = ch1_res_q;
				rdata_d[PING_RTY_LSB +: 3] = ping_rty_q;
				rdata_d[MONO_BIT] = mono_q;
			end
			ADDR_PING_PERIOD: begin
				rdata_d = ping_period_q;
			end
			ADDR_BULK_RETRY: begin
				rdata_d = bulk_limit_q;
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// read data registered one cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			low_power_en_out <= RST_LOW_PWR;
			tx_sink_current_sel_out <= RST_SINK;
			pulse_threshold_sel_out <= RST_THR;
			ch2_overcurrent_limit_out <= RST_OC;
			ch1_overcurrent_limit_out <= RST_OC;
		end else begin
			low_power_en_out <= low_pwr_q;
			tx_sink_current_sel_out <= sink_q;
			pulse_threshold_sel_out <= thr_q;
			ch2_overcurrent_limit_out <= ch2_oc_q;
			ch1_overcurrent_limit_out <= ch1_oc_q;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ch2_enable_out <= RST_CH_EN;
			ch1_enable_out <= RST_CH_EN;
			ch2_resume_request_out <= 1'b0;
			ch1_resume_request_out <= 1'b0;
			mono_slave_out <= RST_MONO;
		end else begin
			ch2_enable_out <= ch2_en_q && !conv_off_q;
			ch1_enable_out <= ch1_en_q && !conv_off_q;
			ch2_resume_request_out <= ch2_res_q;
			ch1_resume_request_out <= ch1_res_q;
			mono_slave_out <= mono_q;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ping_tick_out <= 1'b0;
			converter_off_out <= 1'b0;
			disconnect_out <= 1'b0;
			data_error_out <= 1'b0;
		end else begin
			ping_tick_out <= ping_tick_q;
			converter_off_out <= conv_off_q;
			disconnect_out <= conv_off_q;
			data_error_out <= data_err_q;
		end
	end
endmodule

/* File: plc_slave_model.sv */
// far-side slave model: answers pings, data-out requests and resumes
`timescale 1ns/1ns
module plc_slave_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// requests from the master
	input wire logic ping_in,
	input wire logic dout_req_in,
	input wire logic [1:0] resume_req_in,
	input wire logic refuse_in,
	// answers to the master
	output logic ok_out = 1'b0,
	output logic fail_out = 1'b0,
	output logic ack_out = 1'b0,
	output logic nack_out = 1'b0,
	output logic [1:0] done_out = 2'h0
);
	logic [2:0] slow_q = 3'h0;
	always @(posedge clk_in) begin
		ok_out <= ping_in & ~refuse_in & ~rst_in;
		fail_out <= ping_in & refuse_in & ~rst_in;
		ack_out <= dout_req_in & ~refuse_in;
		nack_out <= dout_req_in & refuse_in;
		slow_q <= (|resume_req_in && !rst_in) ? slow_q + 3'h1 : 3'h0;
		done_out <= (slow_q == 3'h5) ? resume_req_in : 2'h0;
	end
endmodule

/* File: plc_master_config_bank_chk.sv */
// assertions on the configuration bank ports
`timescale 1ns/1ns
module plc_master_config_bank_chk
	import plc_cfg_pkg::*;
(
	// clock, reset and register port
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	// link events
	input wire logic [1:0] resume_done_in,
	input wire logic bulk_mode_in,
	// configuration outputs
	input wire logic low_power_en_out,
	input wire logic [1:0] tx_sink_current_sel_out,
	input wire logic [1:0] pulse_threshold_sel_out,
	input wire logic [2:0] ch1_overcurrent_limit_out,
	input wire logic ch2_enable_out,
	input wire logic ch1_enable_out,
	input wire logic ch1_resume_request_out,
	input wire logic mono_slave_out,
	input wire logic ping_tick_out,
	input wire logic converter_off_out,
	input wire logic disconnect_out,
	input wire logic data_error_out
);
	logic w30, w31, w32, w33, set1;
	assign w30 = reg_wr_in && reg_addr_in == ADDR_SYS_POWER;
	assign w31 = reg_wr_in && reg_addr_in == ADDR_DRIVE;
	assign w32 = reg_wr_in && reg_addr_in == ADDR_OVERCURRENT;
	assign w33 = reg_wr_in && reg_addr_in == ADDR_CHAN_RETRY;
	assign set1 = w33 && reg_wdata_in[CH1_RES_BIT];
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_low_power_write: assert property (
		w30 |-> ##2 low_power_en_out == $past(reg_wdata_in[6], 2))
		else $error("low power enable wrong");
	a_drive_write: assert property (
		w31 |-> ##2 tx_sink_current_sel_out == $past(reg_wdata_in[7:6], 2)
		&& pulse_threshold_sel_out == $past(reg_wdata_in[1:0], 2))
		else $error("drive selection wrong");
	a_limit_write: assert property (
		w32 |-> ##2 ch1_overcurrent_limit_out == $past(reg_wdata_in[2:0], 2))
		else $error("overcurrent limit wrong");
	a_enable_mode: assert property (
		w33 ##2 !converter_off_out |-> mono_slave_out ==
		$past(reg_wdata_in[0], 2) && ch1_enable_out == $past(reg_wdata_in[6], 2))
		else $error("enable or mode wrong");
	a_resume_set: assert property (
		$rose(ch1_resume_request_out) |-> $past(set1, 2))
		else $error("resume rose without write");
	a_resume_clear: assert property (
		resume_done_in[0] && !set1 |-> ##2 !ch1_resume_request_out)
		else $error("resume not cleared");
	a_shutdown_sticky: assert property (
		converter_off_out |=> converter_off_out && disconnect_out
		&& !ch1_enable_out && !ch2_enable_out)
		else $error("shutdown not held");
	a_error_bulk_only: assert property (
		$rose(data_error_out) |-> bulk_mode_in && $past(bulk_mode_in))
		else $error("data error outside bulk mode");
	a_ping_pulse: assert property (
		ping_tick_out |=> !ping_tick_out)
		else $error("ping tick too long");
	cover property (converter_off_out);
	cover property (data_error_out);
	cover property ($fell(ch1_resume_request_out));
endmodule
bind plc_master_config_bank plc_master_config_bank_chk u_chk (.clk_in,
	.rst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .resume_done_in,
	.bulk_mode_in, .low_power_en_out, .tx_sink_current_sel_out,
	.pulse_threshold_sel_out, .ch1_overcurrent_limit_out, .ch2_enable_out,
	.ch1_enable_out, .ch1_resume_request_out, .mono_slave_out, .ping_tick_out,
	.converter_off_out, .disconnect_out, .data_error_out);

/* File: tb_plc_master_config_bank.sv */
// bench for the configuration bank with a far-side slave model
`timescale 1ns/1ns
module tb_plc_master_config_bank;
	import plc_cfg_pkg::*;
	logic clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	logic [1:0] resume_done_in, tx_sink_current_sel_out;
	logic [1:0] pulse_threshold_sel_out;
	logic cmd_ok_in, cmd_fail_in, dout_ack_in, dout_nack_in;
	logic bulk_mode_in = 0, refuse = 0, dout_req = 0;
	logic low_power_en_out, ch2_enable_out, ch1_enable_out, mono_slave_out;
	logic [2:0] ch2_overcurrent_limit_out, ch1_overcurrent_limit_out;
	logic ch2_resume_request_out, ch1_resume_request_out, ping_tick_out;
	logic converter_off_out, disconnect_out, data_error_out;
	int fails = 0, compares = 0, seed = 89341, n, g;
	logic [7:0] a, d;
	logic [7:0] rv [6] = '{8'h40, 8'h41, 8'h36, 8'hc4, 8'h18, 8'hff};
	logic [7:0] sh [6];
	always #20 clk_in = ~clk_in;
	plc_master_config_bank #(.PING_LSB_CYC(10)) u_plc_master_config_bank (
		.clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
		.reg_wdata_in, .reg_rdata_out, .resume_done_in, .cmd_ok_in,
		.cmd_fail_in, .bulk_mode_in, .dout_ack_in, .dout_nack_in,
		.low_power_en_out, .tx_sink_current_sel_out, .pulse_threshold_sel_out,
		.ch2_overcurrent_limit_out, .ch1_overcurrent_limit_out,
		.ch2_enable_out, .ch1_enable_out, .ch2_resume_request_out,
		.ch1_resume_request_out, .mono_slave_out, .ping_tick_out,
		.converter_off_out, .disconnect_out, .data_error_out);
	plc_slave_model u_plc_slave_model (.clk_in, .rst_in,
		.ping_in(ping_tick_out), .dout_req_in(dout_req),
		.resume_req_in({ch2_resume_request_out, ch1_resume_request_out}),
		.refuse_in(refuse), .ok_out(cmd_ok_in), .fail_out(cmd_fail_in),
		.ack_out(dout_ack_in), .nack_out(dout_nack_in),
		.done_out(resume_done_in));
	function automatic logic [7:0] mask(input logic [7:0] ad);
		case (ad)
			ADDR_SYS_POWER: return SYS_POWER_MASK;
			ADDR_DRIVE: return DRIVE_MASK;
			ADDR_OVERCURRENT: return OVERCURRENT_MASK;
			default: return (ad < 8'h30 || ad > 8'h35) ? 8'h00 : 8'hff;
		endcase
	endfunction
	task conclude;
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] v);
		@(negedge clk_in);
		reg_wr_in = 1;
		reg_addr_in = ad;
		reg_wdata_in = v;
		@(negedge clk_in);
		reg_wr_in = 0;
		repeat (2) @(negedge clk_in);
	endtask
	task rd(input logic [7:0] ad, input logic [7:0] e);
		@(negedge clk_in);
		reg_rd_in = 1;
		reg_addr_in = ad;
		@(negedge clk_in);
		reg_rd_in = 0;
		@(negedge clk_in);
		chk(reg_rdata_out, e);
	endtask
	task tick(output int c);
		c = 0;
		do begin
			@(negedge clk_in);
			c++;
		end while (ping_tick_out !== 1'b1 && c < 400);
	endtask
	task ping(input logic r);
		refuse = r;
		tick(g);
		chk(8'(g < 400), 8'h01);
		repeat (6) @(negedge clk_in);
	endtask
	task dout(input logic r);
		refuse = r;
		dout_req = 1;
		@(negedge clk_in);
		dout_req = 0;
		repeat (4) @(negedge clk_in);
	endtask
	task outs;
		chk(low_power_en_out, sh[0][6]);
		chk({tx_sink_current_sel_out, pulse_threshold_sel_out},
			{sh[1][7:6], sh[1][1:0]});
		chk({ch2_overcurrent_limit_out, ch1_overcurrent_limit_out},
			sh[2][5:0]);
		chk({ch2_enable_out, ch1_enable_out, mono_slave_out},
			{sh[3][7:6], sh[3][0]});
	endtask
	initial begin
		sh = rv;
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		for (a = 8'h2f; a < 8'h37; a++) rd(a, mask(a) & rv[a - 8'h30]);
		outs;
		for (n = 0; n < 24; n++) begin
			a = 8'h2e + 8'($unsigned($random(seed)) % 10);
			d = $random(seed);
			if (a == ADDR_CHAN_RETRY) d = d & 8'hcf;
			wr(a, d);
			if (mask(a) != 8'h00) sh[a - 8'h30] = d & mask(a);
			rd(a, d & mask(a));
			outs;
		end
		wr(ADDR_CHAN_RETRY, sh[3] | 8'h30);
		chk({ch2_resume_request_out, ch1_resume_request_out}, 2'h3);
		repeat (12) @(negedge clk_in);
		chk({ch2_resume_request_out, ch1_resume_request_out}, 2'h0);
		rd(ADDR_CHAN_RETRY, sh[3]);
		wr(ADDR_PING_PERIOD, 8'h00);
		bulk_mode_in = 1;
		wr(ADDR_BULK_RETRY, 8'h02);
		for (n = 1; n < 4; n++) begin
			dout(1);
			chk(data_error_out, 8'(n == 3));
		end
		dout(0);
		chk(data_error_out, 8'h00);
		wr(ADDR_BULK_RETRY, BULK_UNLIMITED);
		for (n = 0; n < 20; n++) dout(1);
		chk(data_error_out, 8'h00);
		wr(ADDR_BULK_RETRY, 8'h00);
		bulk_mode_in = 0;
		for (n = 0; n < 3; n++) dout(1);
		chk({data_error_out, converter_off_out}, 8'h00);
		// pings during the period measurement must not count as fails
		refuse = 0;
		// period of 25 steps, the shortest advised
		wr(ADDR_PING_PERIOD, 8'h19);
		tick(g);
		tick(g);
		chk(8'(g), 8'd250);
		wr(ADDR_CHAN_RETRY, 8'hc2);
		ping(1);
		ping(0);
		ping(1);
		chk(converter_off_out, 8'h00);
		ping(1);
		chk({converter_off_out, disconnect_out, ch2_enable_out,
			ch1_enable_out}, 8'h0c);
		rst_in = 1;
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		chk(converter_off_out, 8'h00);
		rd(ADDR_SYS_POWER, 8'h40);
		conclude;
	end
	initial begin
		#2000000;
		fails++;
		conclude;
	end
endmodule
